/* sweep_run_control.sv */
`timescale 1ns/100ps
// Functional notes
// - Remote with trigger enable 1: trigger input starts one sweep; 0 ignores.
// - Local mode always honours the one-shot trigger input.
// - Trigger enable kept across local periods and reapplied in remote.
// - Reset and preset set trigger input remote enable to one.
// - Park-at-start halts any sweep and outputs start frequency.
// - Park-at-stop halts any sweep and outputs stop frequency.
// - Pause command halts running sweep; continue command restarts it.
// - Continue while not paused is ignored, raising no error.
// - Remote: pause input honoured with enable 1, ignored with enable 0.
// - Local mode honours the pause-level input whatever the enable, except during a command pause.
// - Pause enable kept across local periods and restored in remote.
// - Reset and preset set pause input remote enable to one.
// - Enabled pause input low pauses sweep; pause/continue commands ignored.
// - Pause input returning high restarts the sweep it paused.
// - After command pause, pause input ignored until continue command.
// - Duty accepted from 5.0 to 95.0 percent in 0.1 steps.
// - Fixed duty command forces duty to exactly 50 percent.
// - Save settings to slot 0..9; reload a slot's settings.
// - Output switch 0 disables waveform output, 1 enables.
// - Ranging select 0 automatic, 1 fixed.
// - Single start runs one sweep; continuous start repeats.
module sweep_run_control
  import sweep_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic remote_mode,
  input wire logic one_shot_trigger_input,
  input wire logic sweep_pause_input_n,
  input wire logic trigger_enable_write,
  input wire logic trigger_enable_value,
  input wire logic pause_enable_write,
  input wire logic pause_enable_value,
  input wire logic park_at_start_command,
  input wire logic park_at_stop_command,
  input wire logic sweep_pause_command,
  input wire logic sweep_continue_command,
  input wire logic single_sweep_begin_command,
  input wire logic continuous_sweep_begin_command,
  input wire logic sweep_off_command,
  input wire logic preset_command,
  input wire logic modulation_write,
  input wire logic modulation_value,
  input wire logic duty_write,
  input wire logic [duty_w-1:0] duty_value,
  input wire logic fixed_half_duty_command,
  input wire logic settings_save_command,
  input wire logic settings_reload_command,
  input wire logic [slot_w-1:0] slot_number,
  input wire logic output_switch_write,
  input wire logic output_switch_value,
  input wire logic ranging_write,
  input wire logic ranging_value,
  input wire logic [freq_w-1:0] start_freq,
  input wire logic [freq_w-1:0] stop_freq,
  input wire logic [freq_w-1:0] sweep_step,
  output logic [freq_w-1:0] output_freq,
  output logic sweeping,
  output logic sweep_paused,
  output logic trigger_input_remote_enable,
  output logic pause_input_remote_enable,
  output logic amplitude_modulation_switch,
  output logic [duty_w-1:0] square_duty_setting,
  output logic waveform_output_switch,
  output logic output_ranging_select,
  output logic setting_rejected
);
  import sweep_ctl_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    sweep_state_t st;
    logic continuous;
    logic [freq_w-1:0] freq;
    logic trig_en;
    logic pause_en;
    logic mod;
    logic [duty_w-1:0] duty;
    logic out_on;
    logic ranging;
    logic rejected;
    logic reload_pending;
    logic run_flag;
    logic pause_flag;
  } ctl_t;

  ctl_t r;
  ctl_t next_r;
  logic [setting_w-1:0] slot_data;
  logic slot_ok;
  logic trig_live;
  logic pin_pause;
  logic save_go;

  assign slot_ok = (slot_number <= last_slot);
  assign save_go = settings_save_command && slot_ok;

  // Stored image: duty, modulation, output switch, ranging
  settings_store store_u (
    .sys_clk(sys_clk),
    .write_en(save_go),
    .write_slot(slot_number),
    .write_data({r.duty, r.mod, r.out_on, r.ranging, 1'b0}),
    .read_slot(slot_number),
    .read_data(slot_data)
  );

  // ************************************************************
  // Input gating
  // ************************************************************
  // Enables stay stored in local mode, so remote reapplies them
  assign trig_live = one_shot_trigger_input
    && (!remote_mode || r.trig_en);
  assign pin_pause = !sweep_pause_input_n
    && (!remote_mode || r.pause_en);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.rejected = 1'b0;
    next_r.reload_pending = 1'b0;
    if (trigger_enable_write) begin
      next_r.trig_en = trigger_enable_value;
    end
    if (pause_enable_write) begin
      next_r.pause_en = pause_enable_value;
    end
    if (modulation_write) begin
      next_r.mod = modulation_value;
    end
    if (output_switch_write) begin
      next_r.out_on = output_switch_value;
    end
    if (ranging_write) begin
      next_r.ranging = ranging_value;
    end
    if (duty_write) begin
      if (duty_value >= duty_min && duty_value <= duty_max) begin
        next_r.duty = duty_value;
      end else begin
        next_r.rejected = 1'b1;
      end
    end
    if (fixed_half_duty_command) begin
      next_r.duty = duty_half;
    end
    if ((settings_save_command || settings_reload_command) && !slot_ok) begin
      next_r.rejected = 1'b1;
    end
    // Read port lags one cycle, so the copy lands a cycle later
    if (settings_reload_command && slot_ok) begin
      next_r.reload_pending = 1'b1;
    end
    if (r.reload_pending) begin
      {next_r.duty, next_r.mod, next_r.out_on, next_r.ranging} =
        slot_data[setting_w-1:1];
    end
    case (r.st)
      st_idle, st_park_start, st_park_stop: begin
        if (trig_live) begin
          next_r.st = st_run;
          next_r.continuous = 1'b0;
          next_r.freq = start_freq;
        end
      end
      st_run: begin
        if (pin_pause) begin
          next_r.st = st_pin_pause;
        end else if (sweep_pause_command) begin
          next_r.st = st_cmd_pause;
        end else if (r.freq >= stop_freq) begin
          next_r.freq = start_freq;
          if (!r.continuous) begin
            next_r.st = st_idle;
          end
        end else begin
          next_r.freq = freq_w'(r.freq + sweep_step);
        end
      end
      st_cmd_pause: begin
        // Pause pin is not looked at here
        if (sweep_continue_command) begin
          next_r.st = st_run;
        end
      end
      st_pin_pause: begin
        // Pause and continue commands carry no weight while the pin holds
        if (!pin_pause) begin
          next_r.st = st_run;
        end
      end
      default: begin
        next_r.st = st_idle;
      end
    endcase
    // Begin, off, park and preset override the sweep machine
    if (single_sweep_begin_command || continuous_sweep_begin_command) begin
      next_r.st = st_run;
      next_r.continuous = continuous_sweep_begin_command;
      next_r.freq = start_freq;
    end
    if (sweep_off_command) begin
      next_r.st = st_idle;
    end
    if (park_at_start_command) begin
      next_r.st = st_park_start;
      next_r.freq = start_freq;
    end
    if (park_at_stop_command) begin
      next_r.st = st_park_stop;
      next_r.freq = stop_freq;
    end
    if (preset_command) begin
      next_r.trig_en = trig_enable_init;
      next_r.pause_en = pause_enable_init;
      next_r.mod = mod_init;
      next_r.out_on = output_on_init;
      next_r.ranging = ranging_init;
      next_r.duty = duty_half;
      next_r.st = st_idle;
      next_r.continuous = 1'b0;
    end
    // Status outputs registered, not decoded after the flop
    next_r.run_flag = (next_r.st == st_run);
    next_r.pause_flag = (next_r.st == st_cmd_pause)
      || (next_r.st == st_pin_pause);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: st_idle, continuous: 1'b0, freq: '0,
             trig_en: trig_enable_init, pause_en: pause_enable_init,
             mod: mod_init, duty: duty_half, out_on: output_on_init,
             ranging: ranging_init, rejected: 1'b0,
             reload_pending: 1'b0, run_flag: 1'b0,
             pause_flag: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign output_freq = r.freq;
  assign sweeping = r.run_flag;
  assign sweep_paused = r.pause_flag;
  assign trigger_input_remote_enable = r.trig_en;
  assign pause_input_remote_enable = r.pause_en;
  assign amplitude_modulation_switch = r.mod;
  assign square_duty_setting = r.duty;
  assign waveform_output_switch = r.out_on;
  assign output_ranging_select = r.ranging;
  assign setting_rejected = r.rejected;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence quiet_s;
    !single_sweep_begin_command && !continuous_sweep_begin_command
    && !park_at_start_command && !park_at_stop_command
    && !preset_command && !sweep_off_command;
  endsequence

  trig_gate_a: assert property (
    (r.st == st_idle && remote_mode && !r.trig_en) and quiet_s
    |=> r.st == st_idle)
    else $error("trigger taken while disabled in remote");
  trig_local_a: assert property (
    (r.st == st_idle && !remote_mode && one_shot_trigger_input) and quiet_s
    |=> r.st == st_run && r.freq == $past(start_freq))
    else $error("local trigger not honoured");
  preset_en_a: assert property (
    preset_command |=> r.trig_en && r.pause_en)
    else $error("preset did not set enables");
  park_start_a: assert property (
    park_at_start_command && !park_at_stop_command && !preset_command
    |=> r.st == st_park_start && r.freq == $past(start_freq))
    else $error("park at start failed");
  park_stop_a: assert property (
    park_at_stop_command && !preset_command
    |=> r.st == st_park_stop && r.freq == $past(stop_freq))
    else $error("park at stop failed");
  cmd_pause_a: assert property (
    (r.st == st_run && sweep_pause_command && !pin_pause) and quiet_s
    |=> r.st == st_cmd_pause)
    else $error("pause command not taken");
  pin_pause_a: assert property (
    (r.st == st_pin_pause && pin_pause) and quiet_s
    |=> r.st == st_pin_pause)
    else $error("pin pause left early");
  cmd_hold_a: assert property (
    (r.st == st_cmd_pause && !sweep_continue_command) and quiet_s
    |=> r.st == st_cmd_pause && $stable(r.freq))
    else $error("command pause left without continue");
  duty_range_a: assert property (
    r.duty >= duty_min && r.duty <= duty_max)
    else $error("duty out of range");
  half_duty_a: assert property (
    fixed_half_duty_command && !preset_command && !r.reload_pending
    |=> r.duty == duty_half)
    else $error("fixed duty not applied");
  out_sw_a: assert property (
    output_switch_write && !preset_command && !r.reload_pending
    |=> r.out_on == $past(output_switch_value))
    else $error("output switch not applied");
  single_end_a: assert property (
    (r.st == st_run && !r.continuous && r.freq >= stop_freq
    && !pin_pause && !sweep_pause_command) and quiet_s
    |=> r.st == st_idle)
    else $error("single sweep did not end");
endmodule

/* sweep_ctl_pkg.sv */
package sweep_ctl_pkg;
  // ************************************************************
  // Widths and encodings
  // ************************************************************
  localparam int freq_w = 32;
  localparam int duty_w = 10;
  localparam int slot_w = 4;
  localparam int slot_count = 10;
  localparam int setting_w = duty_w + 4;
  // Duty in tenths of a percent
  localparam logic [duty_w-1:0] duty_min = 10'h032;
  localparam logic [duty_w-1:0] duty_max = 10'h3b6;
  localparam logic [duty_w-1:0] duty_half = 10'h1f4;
  // ************************************************************
  // Values after reset or preset; fixed ranging code; last slot
  // ************************************************************
  localparam logic trig_enable_init = 1'b1;
  localparam logic pause_enable_init = 1'b1;
  localparam logic mod_init = 1'b0;
  localparam logic output_on_init = 1'b0;
  localparam logic ranging_init = 1'b0;
  localparam logic fixed_ranging = 1'b1;
  localparam logic [slot_w-1:0] last_slot = 4'h9;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_run = 3'b001,
    st_cmd_pause = 3'b010,
    st_pin_pause = 3'b011,
    st_park_start = 3'b100,
    st_park_stop = 3'b101
  } sweep_state_t;
endpackage

/* settings_store.sv */
`timescale 1ns/100ps
module settings_store
  import sweep_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic write_en,
  input wire logic [slot_w-1:0] write_slot,
  input wire logic [setting_w-1:0] write_data,
  input wire logic [slot_w-1:0] read_slot,
  output logic [setting_w-1:0] read_data
);
  logic [setting_w-1:0] mem [slot_count];

  // Registered read; slots hold no reset value
  always_ff @(posedge sys_clk) begin
    if (write_en) begin
      mem[write_slot] <= write_data;
    end
    read_data <= mem[read_slot];
  end
endmodule

/* sweep_host_model.sv */
`timescale 1ns/100ps
// ************************************************************
// Host side: one-cycle command strobes
// ************************************************************
module sweep_host_model (
  input wire logic sys_clk,
  output logic [16:0] strobe
);
  initial strobe = 17'h0;
  // Gap models a slow host; strobe never stays up past one cycle
  task automatic pulse(input int i, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk) strobe[i] <= 1'h1;
    @(posedge sys_clk) strobe[i] <= 1'h0;
  endtask
endmodule

/* sweep_run_control_tb.sv */
`timescale 1ns/100ps
module sweep_run_control_tb;
  import sweep_ctl_pkg::*;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic remote_mode = 1'h0;
  logic one_shot_trigger_input = 1'h0;
  logic sweep_pause_input_n = 1'h1;
  logic trigger_enable_value = 1'h0;
  logic pause_enable_value = 1'h0;
  logic modulation_value = 1'h1;
  logic output_switch_value = 1'h1;
  logic ranging_value = 1'h1;
  logic [duty_w-1:0] duty_value = 10'h032;
  logic [slot_w-1:0] slot_number = 4'h9;
  logic [freq_w-1:0] start_freq = 32'h64;
  logic [freq_w-1:0] stop_freq = 32'h6e;
  logic [freq_w-1:0] sweep_step = 32'h5;
  logic [freq_w-1:0] output_freq, held;
  logic [duty_w-1:0] square_duty_setting;
  logic sweeping, sweep_paused, setting_rejected;
  logic trigger_input_remote_enable, pause_input_remote_enable;
  logic amplitude_modulation_switch, waveform_output_switch;
  logic output_ranging_select;
  logic [16:0] strobe;
  int error_cnt = 0;
  int n_tests = 0;
  // ************************************************************
  // Instances; strobe bits in the order of the command ports
  // ************************************************************
  sweep_host_model u_sweep_host_model (.sys_clk(sys_clk), .strobe(strobe));
  sweep_run_control u_sweep_run_control (
    .trigger_enable_write(strobe[0]), .pause_enable_write(strobe[1]),
    .park_at_start_command(strobe[2]), .park_at_stop_command(strobe[3]),
    .sweep_pause_command(strobe[4]), .sweep_continue_command(strobe[5]),
    .single_sweep_begin_command(strobe[6]),
    .continuous_sweep_begin_command(strobe[7]),
    .sweep_off_command(strobe[8]), .preset_command(strobe[9]),
    .modulation_write(strobe[10]), .duty_write(strobe[11]),
    .fixed_half_duty_command(strobe[12]),
    .settings_save_command(strobe[13]),
    .settings_reload_command(strobe[14]),
    .output_switch_write(strobe[15]), .ranging_write(strobe[16]), .*);
  always #2.5 sys_clk = ~sys_clk;
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Samples 1 ns after the edge that took the strobe
  task automatic p(input int i);
    u_sweep_host_model.pulse(i, i % 2);
    #1;
  endtask
  task automatic wait_sweep(input logic want);
    int k;
    k = 0;
    while (sweeping !== want && k < 100) begin
      tick(1);
      k++;
    end
    if (sweeping !== want) begin
      chk("sweep_wait", 1'h0, 1'h1);
      wrap_up();
    end
  endtask
  task automatic trig;
    @(posedge sys_clk) one_shot_trigger_input <= 1'h1;
    @(posedge sys_clk) one_shot_trigger_input <= 1'h0;
    #1;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chk("trig_en", 1'h1, trigger_input_remote_enable);
    chk("pin_en", 1'h1, pause_input_remote_enable);
    chk("out", 1'h0, waveform_output_switch);
    chk("range", 1'h0, output_ranging_select);
  endtask
  task automatic t_single;
    p(6);
    chk("run", 1'h1, sweeping);
    chk("freq", start_freq, output_freq);
    wait_sweep(1'h0);
    chk("end_freq", start_freq, output_freq);
    tick(4);
    chk("one_only", 1'h0, sweeping);
  endtask
  task automatic t_hold;
    p(7);
    p(5);
    chk("void_go", 1'h0, sweep_paused);
    chk("running", 1'h1, sweeping);
    p(4);
    held = output_freq;
    chk("paused", 1'h1, sweep_paused);
    tick(4);
    chk("held", held, output_freq);
    p(5);
    chk("resumed", 1'h0, sweep_paused);
    p(3);
    chk("stop_run", 1'h0, sweeping);
    chk("stop_f", stop_freq, output_freq);
    p(7);
    p(2);
    chk("start_run", 1'h0, sweeping);
    chk("start_f", start_freq, output_freq);
  endtask
  task automatic t_pin;
    p(7);
    @(posedge sys_clk) sweep_pause_input_n <= 1'h0;
    tick(2);
    chk("pin_hold", 1'h1, sweep_paused);
    p(5);
    chk("cmd_void", 1'h1, sweep_paused);
    @(posedge sys_clk) sweep_pause_input_n <= 1'h1;
    tick(2);
    chk("pin_go", 1'h0, sweep_paused);
    p(4);
    @(posedge sys_clk) sweep_pause_input_n <= 1'h0;
    @(posedge sys_clk) sweep_pause_input_n <= 1'h1;
    tick(2);
    chk("cmd_keeps", 1'h1, sweep_paused);
    p(5);
    chk("cmd_go", 1'h0, sweep_paused);
    p(8);
    chk("off", 1'h0, sweeping);
  endtask
  task automatic t_remote;
    @(posedge sys_clk) remote_mode <= 1'h1;
    p(0);
    chk("trig_off", 1'h0, trigger_input_remote_enable);
    trig();
    chk("trig_void", 1'h0, sweeping);
    @(posedge sys_clk) remote_mode <= 1'h0;
    trig();
    chk("local_trig", 1'h1, sweeping);
    wait_sweep(1'h0);
    @(posedge sys_clk) remote_mode <= 1'h1;
    trig();
    chk("trig_kept", 1'h0, sweeping);
    p(1);
    p(7);
    @(posedge sys_clk) sweep_pause_input_n <= 1'h0;
    tick(2);
    chk("pin_void", 1'h0, sweep_paused);
    @(posedge sys_clk) remote_mode <= 1'h0;
    tick(2);
    chk("local_pin", 1'h1, sweep_paused);
    @(posedge sys_clk) sweep_pause_input_n <= 1'h1;
    @(posedge sys_clk) remote_mode <= 1'h1;
    tick(1);
    chk("pin_kept", 1'h0, pause_input_remote_enable);
    p(9);
    chk("pst_trig", 1'h1, trigger_input_remote_enable);
    chk("pst_pin", 1'h1, pause_input_remote_enable);
    trig();
    chk("trig_on", 1'h1, sweeping);
    wait_sweep(1'h0);
  endtask
  task automatic t_set;
    p(11);
    chk("duty_min", duty_min, square_duty_setting);
    @(posedge sys_clk) duty_value <= 10'h031;
    p(11);
    chk("rej_lo", 1'h1, setting_rejected);
    @(posedge sys_clk) duty_value <= 10'h3b7;
    p(11);
    chk("rej_hi", 1'h1, setting_rejected);
    chk("duty_kept", duty_min, square_duty_setting);
    @(posedge sys_clk) duty_value <= 10'h3b6;
    p(12);
    chk("half", duty_half, square_duty_setting);
    p(11);
    chk("duty_max", duty_max, square_duty_setting);
    p(10);
    p(15);
    p(16);
    chk("out_on", 1'h1, waveform_output_switch);
    chk("fixed", fixed_ranging, output_ranging_select);
    p(13);
    p(9);
    p(14);
    tick(1);
    chk("rcl_duty", duty_max, square_duty_setting);
    chk("rcl_mod", 1'h1, amplitude_modulation_switch);
    chk("rcl_out", 1'h1, waveform_output_switch);
    chk("rcl_rng", 1'h1, output_ranging_select);
    @(posedge sys_clk) slot_number <= 4'ha;
    p(13);
    chk("rej_slot", 1'h1, setting_rejected);
    @(posedge sys_clk) output_switch_value <= 1'h0;
    p(15);
    chk("out_off", 1'h0, waveform_output_switch);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'h1;
    tick(1);
    t_reset();
    t_single();
    t_hold();
    t_pin();
    t_remote();
    t_set();
    wrap_up();
  end
endmodule
